/* verilog/itc_identify_words.sv */
// Purpose: Read-only transfer capability words of the identify data block
// Assumes: Configuration is stable while a read or stream is in progress
// Notes: Single reads by index, or a stream of words 63..79 in order
`timescale 1ns/10ps
`default_nettype none

module itc_identify_words
   import itc_pkg::*;
(
   input wire logic SYS_CLK_IN,
   input wire logic RSTN_IN,
   input wire itc_cfg_s CFG_IN,
   input wire logic START_IN,
   input wire logic READ_IN,
   input wire logic [7:0] INDEX_IN,
   output logic [15:0] DATA_OUT,
   output logic VALID_OUT,
   output logic LAST_OUT,
   output logic BUSY_OUT,
   output logic TIMING_VALID_OUT
);

   // ----------------------------------------------------------------
   // Word selection
   // ----------------------------------------------------------------

   // Word at a given index; others read zero
   function automatic logic [15:0] word_at(input itc_words_s w, input logic [7:0] idx);
      logic [15:0] r;
      r = ITC_WORD_RST;
      unique case (idx)
         ITC_W_MDMA: r = w.mdma;
         ITC_W_PIO: r = w.pio;
         ITC_W_DMA_MIN: r = w.dma_min;
         ITC_W_DMA_REC: r = w.dma_rec;
         ITC_W_PIO_NF: r = w.pio_nf;
         ITC_W_PIO_FC: r = w.pio_fc;
         ITC_W_QDEPTH: r = w.qdepth;
         ITC_W_SER_CAP: r = w.ser_cap;
         ITC_W_FEAT_SUP: r = w.feat_sup;
         ITC_W_FEAT_EN: r = w.feat_en;
         default: r = ITC_WORD_RST;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------

   itc_state_e state;
   itc_state_e next_state;
   itc_cfg_s snap;
   itc_words_s words;
   logic [7:0] idx;
   logic [7:0] out_idx;
   logic stream_end;

   // Word builder on the snapshot
   itc_word_build u_build (
      .cfg_in(snap),
      .words_out(words)
   );

   assign stream_end = (state == ITC_STREAM) && (idx == ITC_W_LAST);

   // Next state; requests only taken while idle, start wins
   always_comb begin
      next_state = state;
      unique case (state)
         ITC_IDLE: begin
            if (START_IN) begin
               next_state = ITC_STREAM;
            end else if (READ_IN) begin
               next_state = ITC_SINGLE;
            end
         end
         ITC_STREAM: begin
            if (stream_end) begin
               next_state = ITC_IDLE;
            end
         end
         ITC_SINGLE: next_state = ITC_IDLE;
         default: next_state = ITC_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         state <= ITC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Configuration snapshot taken with the request
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         snap <= '0;
      end else if (state == ITC_IDLE && (START_IN || READ_IN)) begin
         snap <= CFG_IN;
      end
   end

   // Word index walk
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         idx <= 8'h00;
      end else if (state == ITC_IDLE) begin
         idx <= START_IN ? ITC_W_FIRST : INDEX_IN;
      end else if (state == ITC_STREAM) begin
         idx <= idx + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Read data path; no write path exists
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         DATA_OUT <= ITC_WORD_RST;
         VALID_OUT <= 1'b0;
         LAST_OUT <= 1'b0;
         out_idx <= 8'h00;
      end else begin
         DATA_OUT <= ITC_WORD_RST;
         VALID_OUT <= 1'b0;
         LAST_OUT <= 1'b0;
         if (state != ITC_IDLE) begin
            DATA_OUT <= word_at(words, idx);
            VALID_OUT <= 1'b1;
            LAST_OUT <= stream_end || (state == ITC_SINGLE);
            out_idx <= idx;
         end
      end
   end

   // Busy while a transfer is pending
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         BUSY_OUT <= 1'b0;
      end else begin
         BUSY_OUT <= (next_state != ITC_IDLE);
      end
   end

   // Timing words always present, reading zero when unimplemented, so the flag rises after reset
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         TIMING_VALID_OUT <= 1'b0;
      end else begin
         TIMING_VALID_OUT <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (!RSTN_IN);

   a_sel_one_hot: assert property (
      VALID_OUT && out_idx == ITC_W_MDMA |-> $onehot0(DATA_OUT[15:8]))
      else $error("More than one MDMA mode selected");

   a_sel_reserved: assert property (
      VALID_OUT && out_idx == ITC_W_MDMA |-> DATA_OUT[15:11] == 5'h00)
      else $error("Reserved MDMA select bits set");

   a_sel_follows_cfg: assert property (
      state == ITC_SINGLE && snap.mdma_sel_en && snap.mdma_sel == 2'h1
      && idx == ITC_W_MDMA |=> DATA_OUT[9] == (snap.mdma_sup[1] | snap.mdma_sup[2]))
      else $error("MDMA mode 1 select bit wrong");

   a_sup_cumul: assert property (
      VALID_OUT && out_idx == ITC_W_MDMA |-> DATA_OUT[7:3] == 5'h00
      && !(DATA_OUT[2] && !DATA_OUT[1]) && !(DATA_OUT[1] && !DATA_OUT[0]))
      else $error("MDMA support bits not cumulative");

   a_timing_flag: assert property (
      BUSY_OUT |-> TIMING_VALID_OUT)
      else $error("Timing-valid flag low during transfer");

   a_pio_reserved: assert property (
      VALID_OUT && out_idx == ITC_W_PIO |-> DATA_OUT[15:2] == 14'h0000)
      else $error("Reserved PIO mode bits set");

   a_dma_floor: assert property (
      snap.mdma_sup[2] |-> words.dma_min >= ITC_MDMA2_NS)
      else $error("DMA minimum below mode 2 cycle");

   a_rec_ge_min: assert property (
      words.dma_rec >= words.dma_min)
      else $error("Recommended DMA cycle below minimum");

   a_unimpl_zero: assert property (
      snap.mdma_sup[2:1] == 2'h0 && snap.time_impl[1:0] == 2'h0
      |-> words.dma_min == ITC_WORD_RST && words.dma_rec == ITC_WORD_RST)
      else $error("Unimplemented DMA time not zero");

   a_pio_order: assert property (
      words.pio_nf == ITC_WORD_RST || words.pio_nf >= words.pio_fc)
      else $error("PIO no-flow time below IORDY time");

   a_pio_fastest: assert property (
      snap.pio_adv[1] |-> words.pio_fc == ITC_PIO4_NS)
      else $error("IORDY time not PIO mode 4");

   a_qdepth_field: assert property (
      VALID_OUT && out_idx == ITC_W_QDEPTH |-> DATA_OUT[15:5] == 11'h000)
      else $error("Queue depth upper bits set");

   a_qdepth_zero: assert property (
      !(snap.q_queued && snap.q_fpdma) |-> words.qdepth == ITC_WORD_RST)
      else $error("Queue depth not zero without queuing");

   a_cap_reserved: assert property (
      VALID_OUT && out_idx == ITC_W_SER_CAP
      |-> DATA_OUT[15:11] == 5'h00 && DATA_OUT[7:3] == 5'h00 && !DATA_OUT[0])
      else $error("Serial capability reserved bits set");

   a_feat_layout: assert property (
      VALID_OUT && (out_idx == ITC_W_FEAT_SUP || out_idx == ITC_W_FEAT_EN)
      |-> DATA_OUT[15:7] == 9'h000 && !DATA_OUT[0])
      else $error("Feature word reserved bits set");

   a_stream_order: assert property (
      VALID_OUT && !LAST_OUT |=> VALID_OUT && out_idx == $past(out_idx) + 8'h01)
      else $error("Stream out of index order");

   a_stream_len: assert property (
      state == ITC_IDLE && START_IN |-> ##18 VALID_OUT && LAST_OUT
      && out_idx == ITC_W_LAST)
      else $error("Stream did not end at last word");

   c_stream_done: cover property (
      state == ITC_IDLE && START_IN ##18 LAST_OUT);

   c_single_read: cover property (
      state == ITC_SINGLE ##1 VALID_OUT && LAST_OUT);

   c_mode2_sel: cover property (
      VALID_OUT && out_idx == ITC_W_MDMA && DATA_OUT[10]);

   c_queue_depth: cover property (
      VALID_OUT && out_idx == ITC_W_QDEPTH && DATA_OUT[4:0] == 5'h1F);

endmodule
`default_nettype wire

/* inc/itc_pkg.sv */
// Purpose: Constants and types for the transfer capability identify words
// Assumes: Words are indexed by their identify-data word number
// Notes: Cycle times are in nanoseconds
//
// Notes on behaviour
// - Selected MDMA mode upper byte, one bit max
// - Bits 8,9,10 select modes 0,1,2; rest reserved
// - Low byte bits 0..2 report cumulative MDMA support
// - Timing-valid flag set when MDMA fields present
// - Faster modes only reported in vendor word
// - PIO word: bit1 mode 4, bit0 mode 3
// - Min DMA cycle not below fastest mode
// - Recommended DMA cycle not below minimum
// - Unimplemented cycle-time field returns zero
// - PIO no-flow time not below IORDY time
// - IORDY PIO time is fastest supported mode
// - Queue depth field holds depth minus one
// - Queue depth zero without queued commands
// - Bits 10,9,8 flag counters, HIPM, NCQ
// - Bits 2,1 flag speeds; bit 0 zero
// - Feature-support bits 6..1 in fixed order
// - Feature-enabled word mirrors support layout
// - Timing-valid flag means timing words valid

package itc_pkg;

   // ----------------------------------------------------------------
   // Word indices
   // ----------------------------------------------------------------
   localparam logic [7:0] ITC_W_MDMA = 8'h3F;
   localparam logic [7:0] ITC_W_PIO = 8'h40;
   localparam logic [7:0] ITC_W_DMA_MIN = 8'h41;
   localparam logic [7:0] ITC_W_DMA_REC = 8'h42;
   localparam logic [7:0] ITC_W_PIO_NF = 8'h43;
   localparam logic [7:0] ITC_W_PIO_FC = 8'h44;
   localparam logic [7:0] ITC_W_QDEPTH = 8'h4B;
   localparam logic [7:0] ITC_W_SER_CAP = 8'h4C;
   localparam logic [7:0] ITC_W_FEAT_SUP = 8'h4E;
   localparam logic [7:0] ITC_W_FEAT_EN = 8'h4F;
   localparam logic [7:0] ITC_W_FIRST = 8'h3F;
   localparam logic [7:0] ITC_W_LAST = 8'h4F;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ITC_SEL_LSB = 8;
   localparam int ITC_CAP_LSB = 8;
   localparam int ITC_SPEED_LSB = 1;
   localparam int ITC_FEAT_LSB = 1;

   // Minimum cycle time per defined mode, ns
   localparam logic [15:0] ITC_MDMA0_NS = 16'h01E0;
   localparam logic [15:0] ITC_MDMA1_NS = 16'h0096;
   localparam logic [15:0] ITC_MDMA2_NS = 16'h0078;
   localparam logic [15:0] ITC_PIO3_NS = 16'h00B4;
   localparam logic [15:0] ITC_PIO4_NS = 16'h0078;
   localparam logic [15:0] ITC_WORD_RST = 16'h0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] mdma_sup;    // Highest MDMA mode flags 2..0
      logic mdma_sel_en;       // An MDMA mode is selected
      logic [1:0] mdma_sel;    // Selected MDMA mode number
      logic [1:0] pio_adv;     // PIO 4, PIO 3 supported
      logic [3:0] time_impl;   // Fields 68,67,66,65 implemented
      logic [15:0] dma_min_ns;
      logic [15:0] dma_rec_ns;
      logic [15:0] pio_nf_ns;
      logic [15:0] pio_fc_ns;
      logic [4:0] q_depth_m1;
      logic q_queued;          // Queued DMA commands supported
      logic q_fpdma;           // First-party DMA supported
      logic [2:0] ser_cap;     // Counters, HIPM, NCQ
      logic [1:0] ser_speed;   // 3.0 Gb/s, 1.5 Gb/s
      logic [5:0] feat_sup;
      logic [5:0] feat_en;
   } itc_cfg_s;

   typedef struct packed {
      logic [15:0] mdma;
      logic [15:0] pio;
      logic [15:0] dma_min;
      logic [15:0] dma_rec;
      logic [15:0] pio_nf;
      logic [15:0] pio_fc;
      logic [15:0] qdepth;
      logic [15:0] ser_cap;
      logic [15:0] feat_sup;
      logic [15:0] feat_en;
   } itc_words_s;

   typedef enum logic [1:0] {
      ITC_IDLE = 2'b00,
      ITC_STREAM = 2'b01,
      ITC_SINGLE = 2'b10
   } itc_state_e;

endpackage

/* verilog/itc_word_build.sv */
// Purpose: Builds the ten capability words from a configuration snapshot
// Assumes: Purely combinational; caller registers the result
// Notes: Reserved bits are forced to zero
`timescale 1ns/10ps
`default_nettype none

module itc_word_build
   import itc_pkg::*;
(
   input wire itc_cfg_s cfg_in,
   output var itc_words_s words_out
);

   // Larger of two cycle times
   function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
      max16 = (a > b) ? a : b;
   endfunction

   logic [2:0] sup;
   logic [2:0] sel;
   logic dma_impl;
   logic pio_impl;
   logic pio_nf_impl;
   logic [15:0] dma_floor;
   logic [15:0] dma_min;
   logic [15:0] pio_fc;

   // Cumulative MDMA support and guarded selection
   always_comb begin
      sup = {cfg_in.mdma_sup[2], |cfg_in.mdma_sup[2:1], |cfg_in.mdma_sup};
      sel = 3'h0;
      if (cfg_in.mdma_sel_en && cfg_in.mdma_sel != 2'h3 && sup[cfg_in.mdma_sel]) begin
         sel[cfg_in.mdma_sel] = 1'b1;
      end
   end

   // Cycle-time fields and their implementation flags
   always_comb begin
      dma_impl = cfg_in.time_impl[0] | cfg_in.time_impl[1] | (|cfg_in.mdma_sup[2:1]);
      pio_impl = cfg_in.time_impl[3] | (|cfg_in.pio_adv);
      pio_nf_impl = cfg_in.time_impl[2] | (|cfg_in.pio_adv);
      dma_floor = sup[2] ? ITC_MDMA2_NS : (sup[1] ? ITC_MDMA1_NS : ITC_MDMA0_NS);
      dma_min = dma_impl ? max16(cfg_in.dma_min_ns, dma_floor) : ITC_WORD_RST;
      if (cfg_in.pio_adv[1]) begin
         pio_fc = ITC_PIO4_NS;
      end else if (cfg_in.pio_adv[0]) begin
         pio_fc = ITC_PIO3_NS;
      end else begin
         pio_fc = pio_impl ? cfg_in.pio_fc_ns : ITC_WORD_RST;
      end
   end

   // Word assembly
   always_comb begin
      words_out.mdma = {5'h00, sel, 5'h00, sup};
      words_out.pio = {14'h0000, cfg_in.pio_adv};
      words_out.dma_min = dma_min;
      words_out.dma_rec = dma_impl ? max16(cfg_in.dma_rec_ns, dma_min) : ITC_WORD_RST;
      words_out.pio_nf = pio_nf_impl ? max16(cfg_in.pio_nf_ns, pio_fc) : ITC_WORD_RST;
      words_out.pio_fc = pio_fc;
      words_out.qdepth = (cfg_in.q_queued && cfg_in.q_fpdma) ?
         {11'h000, cfg_in.q_depth_m1} : ITC_WORD_RST;
      words_out.ser_cap = {5'h00, cfg_in.ser_cap, 5'h00, cfg_in.ser_speed, 1'b0};
      words_out.feat_sup = {9'h000, cfg_in.feat_sup, 1'b0};
      words_out.feat_en = {9'h000, cfg_in.feat_en & cfg_in.feat_sup, 1'b0};
   end

endmodule
`default_nettype wire

/* tb/itc_host_model.sv */
// Purpose: Host side that requests identify words, one at a time or as a stream
// Assumes: Requests launched 1 ns after the rising edge
// Notes: The index bus shows inverted data once released
`timescale 1ns/10ps
`default_nettype none

module itc_host_model
   import itc_pkg::*;
(
   input wire logic clk_in,
   input wire logic [15:0] data_in,
   input wire logic valid_in,
   input wire logic last_in,
   output logic start_out,
   output logic read_out,
   output logic [7:0] index_out
);
   logic [15:0] words [0:16];
   logic lasts [0:16];

   initial begin
      start_out = 1'b0;
      read_out = 1'b0;
      index_out = 8'h00;
   end

   // Wait for one answer word under a bounded count
   task automatic wait_word();
      int n;
      n = 0;
      while (valid_in !== 1'b1 && n < 40) begin
         @(posedge clk_in);
         #1;
         n++;
      end
   endtask

   // Single read of one word index
   task automatic single(input logic [7:0] idx, output logic [15:0] d, output logic l);
      @(posedge clk_in);
      #1 read_out = 1'b1;
      index_out = idx;
      @(posedge clk_in);
      #1 read_out = 1'b0;
      index_out = ~idx;
      wait_word();
      d = data_in;
      l = last_in;
   endtask

   // Stream of all seventeen words, captured in arrival order
   task automatic stream();
      @(posedge clk_in);
      #1 start_out = 1'b1;
      @(posedge clk_in);
      #1 start_out = 1'b0;
      for (int k = 0; k < 17; k++) begin
         wait_word();
         words[k] = data_in;
         lasts[k] = last_in;
         @(posedge clk_in);
         #1;
      end
   endtask
endmodule
`default_nettype wire

/* tb/itc_identify_words_tb_top.sv */
// Purpose: Self-checking bench for the transfer capability identify words
// Assumes: Three fixed configurations with hand-worked word tables
// Notes: Each configuration is read as a stream and then word by word
`timescale 1ns/10ps
`default_nettype none

module itc_identify_words_tb_top;
   import itc_pkg::*;

   logic clk = 1'b0;
   logic rstn = 1'b0;
   itc_cfg_s cfg = '0;
   logic start, read, valid, last, busy, tvalid;
   logic [7:0] index;
   logic [7:0] widx;
   logic [15:0] data;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [15:0] d;
   logic l;
   // Expected words 63..68, 75, 76, 78, 79 per configuration
   logic [15:0] exp_tab [0:2][0:9] = '{
      '{16'h0407, 16'h0003, 16'h0078, 16'h0078, 16'h0078, 16'h0078,
        16'h001F, 16'h0706, 16'h007E, 16'h002A},
      '{16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0202, 16'h0002, 16'h0002},
      '{16'h0203, 16'h0001, 16'h0200, 16'h0200, 16'h0100, 16'h00B4,
        16'h0000, 16'h0404, 16'h0054, 16'h0054}};

   // Free-running 50 MHz clock
   initial begin
      forever #10 clk = ~clk;
   end

   itc_identify_words i_dut (
      .SYS_CLK_IN(clk), .RSTN_IN(rstn), .CFG_IN(cfg), .START_IN(start),
      .READ_IN(read), .INDEX_IN(index), .DATA_OUT(data), .VALID_OUT(valid),
      .LAST_OUT(last), .BUSY_OUT(busy), .TIMING_VALID_OUT(tvalid));

   itc_host_model i_host (
      .clk_in(clk), .data_in(data), .valid_in(valid), .last_in(last),
      .start_out(start), .read_out(read), .index_out(index));

   // Expected word for a configuration and index; gaps read zero
   function automatic logic [15:0] exp_word(input int c, input logic [7:0] idx);
      case (idx)
         8'h3F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44: return exp_tab[c][idx - 8'h3F];
         8'h4B: return exp_tab[c][6];
         8'h4C: return exp_tab[c][7];
         8'h4E: return exp_tab[c][8];
         8'h4F: return exp_tab[c][9];
         default: return 16'h0000;
      endcase
   endfunction

   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Load one of the three test configurations while idle
   task automatic set_cfg(input int c);
      @(posedge clk);
      #1 cfg = '0;
      case (c)
         0: begin
            cfg.mdma_sup = 3'b100; cfg.mdma_sel_en = 1'b1; cfg.mdma_sel = 2'd2;
            cfg.pio_adv = 2'b11; cfg.time_impl = 4'hF; cfg.dma_min_ns = 16'h0050;
            cfg.dma_rec_ns = 16'h0064; cfg.pio_nf_ns = 16'h0010; cfg.pio_fc_ns = 16'h0200;
            cfg.q_depth_m1 = 5'h1F; cfg.q_queued = 1'b1; cfg.q_fpdma = 1'b1;
            cfg.ser_cap = 3'b111; cfg.ser_speed = 2'b11; cfg.feat_sup = 6'h3F;
            cfg.feat_en = 6'h15;
         end
         1: begin
            cfg.mdma_sup = 3'b001; cfg.mdma_sel_en = 1'b1; cfg.mdma_sel = 2'd2;
            cfg.dma_min_ns = 16'h0200; cfg.pio_fc_ns = 16'h0200;
            cfg.q_depth_m1 = 5'h05; cfg.q_queued = 1'b1; cfg.ser_cap = 3'b010;
            cfg.ser_speed = 2'b01; cfg.feat_sup = 6'h01; cfg.feat_en = 6'h3F;
         end
         default: begin
            cfg.mdma_sup = 3'b010; cfg.mdma_sel_en = 1'b1; cfg.mdma_sel = 2'd1;
            cfg.pio_adv = 2'b01; cfg.dma_min_ns = 16'h0200; cfg.dma_rec_ns = 16'h0100;
            cfg.pio_nf_ns = 16'h0100; cfg.pio_fc_ns = 16'h0050; cfg.q_depth_m1 = 5'h07;
            cfg.q_fpdma = 1'b1; cfg.ser_cap = 3'b100; cfg.ser_speed = 2'b10;
            cfg.feat_sup = 6'h2A; cfg.feat_en = 6'h3F;
         end
      endcase
   endtask

   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      @(posedge clk);
      #1;
      cmp16({15'h0000, tvalid}, 16'h0001);
      cmp16({14'h0000, valid, busy}, 16'h0000);
      for (int c = 0; c < 3; c++) begin
         set_cfg(c);
         // Busy must rise on the same edge that takes the start
         fork
            i_host.stream();
            begin
               repeat (2) @(posedge clk);
               #1 cmp16({15'h0000, busy}, 16'h0001);
            end
         join
         cmp16({15'h0000, busy}, 16'h0000);
         for (int k = 0; k < 17; k++) begin
            cmp16(i_host.words[k], exp_word(c, 8'h3F + k[7:0]));
            cmp16({15'h0000, i_host.lasts[k]}, {15'h0000, k == 16});
         end
         for (int k = 0; k < 19; k++) begin
            widx = (k == 17) ? 8'h00 : (k == 18) ? 8'hFF : 8'h3F + k[7:0];
            i_host.single(widx, d, l);
            cmp16(d, exp_word(c, (k > 16) ? 8'h00 : 8'h3F + k[7:0]));
            cmp16({15'h0000, l}, 16'h0001);
         end
      end
      cmp16({15'h0000, tvalid}, 16'h0001);
      tally_and_finish();
   end
endmodule
`default_nettype wire
